// [logic/external_irq_latch.sv]
// External interrupt latch: pin edge/level capture, acknowledge, masking, AXI4-Lite registers
// How it works
// - Falling pin edge always sets the latch
// - Vector fetch acknowledge clears the latch
// - Writing one to acknowledge bit clears latch
// - Reset clears the latch
// - Level mode: clear needs acknowledge and high pin
// - Edge mode: acknowledge clears immediately
// - Mask bit holds request from CPU
// - Edges after software acknowledge set again
// - Serviced request uses vector FFFA/FFFB
// - CPU global mask also blocks request
// - Break with clear-enable low: acknowledge-bit write ignored
// - Break with clear-enable high: acknowledge clears
// - Acknowledge bit write-only, reads zero
// - Mask and trigger bits read/write, reset zero
// - Flag bit shows latched event
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module external_irq_latch (
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      ext_int_pin_n_i,
	input  wire logic                      vector_fetch_i,
	input  wire logic                      cpu_int_mask_i,
	input  wire logic                      break_state_i,
	input  wire ext_irq_pkg::axi_wr_req_t  wr_req_i,
	output var  ext_irq_pkg::axi_wr_rsp_t  wr_rsp_o,
	input  wire ext_irq_pkg::axi_rd_req_t  rd_req_i,
	output var  ext_irq_pkg::axi_rd_rsp_t  rd_rsp_o,
	output logic                           cpu_irq_req_o,
	output logic [15:0]                    vector_addr_o,
	output logic                           event_irq_o
);
	import ext_irq_pkg::*;

	//--------------------------------------------------------------
	// Pin synchroniser and detection
	//--------------------------------------------------------------
	logic [2:0] pin_sync_q;
	logic       pin_q;
	logic       fall_edge;
	logic       pin_low;

	// Three stages; stage 0 is read only by stage 1
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_sync_q <= 3'h7;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], ext_int_pin_n_i};
		end
	end

	// Stable level only changes once stages one and two agree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_q <= 1'b1;
		end else if (pin_sync_q[1] == pin_sync_q[2]) begin
			pin_q <= pin_sync_q[2];
		end
	end

	assign fall_edge = pin_q && (pin_sync_q[1] == pin_sync_q[2]) && !pin_sync_q[2];
	assign pin_low   = !pin_q;

	//--------------------------------------------------------------
	// Bus write path
	//--------------------------------------------------------------
	logic        aw_held_q;
	logic        w_held_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        wr_fire;
	logic        wr_hit;
	logic        awready_q;
	logic        wready_q;
	logic        aw_held_d;
	logic        w_held_d;
	logic        bvalid_d;

	assign wr_rsp_o.awready = awready_q;
	assign wr_rsp_o.wready  = wready_q;
	assign wr_rsp_o.bvalid  = bvalid_q;
	assign wr_rsp_o.bresp   = bresp_q;
	assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

	// Address and data taken in either order; write happens once both are held
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (wr_req_i.awvalid && wr_rsp_o.awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= wr_req_i.awaddr;
			end
			if (wr_req_i.wvalid && wr_rsp_o.wready) begin
				w_held_q <= 1'b1;
				w_data_q <= wr_req_i.wdata;
				w_strb_q <= wr_req_i.wstrb;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && wr_req_i.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Next held and response state, so that the ready outputs can come from flops
	always_comb begin
		aw_held_d = aw_held_q || (wr_req_i.awvalid && awready_q);
		w_held_d  = w_held_q || (wr_req_i.wvalid && wready_q);
		bvalid_d  = bvalid_q && !wr_req_i.bready;
		if (wr_fire) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
		end
	end

	// Registered ready: low while a channel is held or a response waits
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
		end else begin
			awready_q <= !aw_held_d && !bvalid_d;
			wready_q  <= !w_held_d && !bvalid_d;
		end
	end

	// Unmapped address answers SLVERR
	always_comb begin
		unique case ({aw_addr_q[7:2], 2'b00})
			OFF_STATUS_CONTROL, OFF_BREAK_CTRL, OFF_EVT_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	//--------------------------------------------------------------
	// Control registers
	//--------------------------------------------------------------
	logic       mode_q;
	logic       mask_q;
	logic       brk_clr_en_q;
	logic [1:0] evt_mask_q;
	logic       wr_sc;
	logic       sw_ack;

	assign wr_sc  = wr_fire && ({aw_addr_q[7:2], 2'b00} == OFF_STATUS_CONTROL) && w_strb_q[0];
	assign sw_ack = wr_sc && w_data_q[BIT_ACK] && (!break_state_i || brk_clr_en_q);

	// Mode and mask are plain read/write bits, cleared by reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= RST_STATUS_CONTROL[BIT_MODE];
			mask_q <= RST_STATUS_CONTROL[BIT_MASK];
		end else if (wr_sc) begin
			mode_q <= w_data_q[BIT_MODE];
			mask_q <= w_data_q[BIT_MASK];
		end
	end

	// Break clear-enable and event mask
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			brk_clr_en_q <= RST_BREAK_CTRL[BIT_BRK_CLR_EN];
			evt_mask_q   <= RST_EVT_MASK;
		end else if (wr_fire && w_strb_q[0]) begin
			if ({aw_addr_q[7:2], 2'b00} == OFF_BREAK_CTRL) begin
				brk_clr_en_q <= w_data_q[BIT_BRK_CLR_EN];
			end
			if ({aw_addr_q[7:2], 2'b00} == OFF_EVT_MASK) begin
				evt_mask_q <= w_data_q[1:0];
			end
		end
	end

	//--------------------------------------------------------------
	// Interrupt latch
	//--------------------------------------------------------------
	logic latch_q;
	logic ack_pend_q;
	logic ack_any;

	// Vector fetch acknowledges only when this latch is the one being serviced
	assign ack_any = sw_ack || (vector_fetch_i && cpu_irq_req_o);

	// Edge sets; acks clear. Set wins so an edge coincident with ack is kept
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			latch_q    <= 1'b0;
			ack_pend_q <= 1'b0;
		end else if (fall_edge) begin
			latch_q    <= 1'b1;
			ack_pend_q <= 1'b0;
		end else if (!mode_q) begin
			ack_pend_q <= 1'b0;
			if (ack_any) begin
				latch_q <= 1'b0;
			end
		end else if ((ack_any || ack_pend_q) && latch_q) begin
			// Level mode: clear waits for pin high, in either order
			if (pin_low) begin
				ack_pend_q <= 1'b1;
			end else begin
				latch_q    <= 1'b0;
				ack_pend_q <= 1'b0;
			end
		end
	end

	//--------------------------------------------------------------
	// CPU request and vector
	//--------------------------------------------------------------
	// Both the module mask and the CPU global mask hold off the request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cpu_irq_req_o <= 1'b0;
			vector_addr_o <= VEC_ADDR_HI;
		end else begin
			cpu_irq_req_o <= latch_q && !mask_q && !cpu_int_mask_i && !ack_any;
			vector_addr_o <= VEC_ADDR_HI; // low byte at VEC_ADDR_LO
		end
	end

	//--------------------------------------------------------------
	// Sticky events and read path
	//--------------------------------------------------------------
	logic [1:0]  evt_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        rd_take;
	logic        rd_evt;
	logic        arready_q;

	assign rd_take = rd_req_i.arvalid && !rvalid_q;
	assign rd_evt  = rd_take && ({rd_req_i.araddr[7:2], 2'b00} == OFF_EVT_STATUS);

	// Read clears; new event in same cycle wins
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			evt_q <= 2'h0;
		end else begin
			evt_q[EVT_LATCH] <= fall_edge || (evt_q[EVT_LATCH] && !rd_evt);
			evt_q[EVT_ACK]   <= ack_any || (evt_q[EVT_ACK] && !rd_evt);
		end
	end

	// One level interrupt while any unmasked sticky event is set
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			event_irq_o <= 1'b0;
		end else begin
			event_irq_o <= |(evt_q & evt_mask_q);
		end
	end

	// Registered read ready: low from the take until the data is accepted
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			arready_q <= 1'b1;
		end else begin
			arready_q <= !(rd_take || (rvalid_q && !rd_req_i.rready));
		end
	end

	// Read response comes straight from its flops
	assign rd_rsp_o.arready = arready_q;
	assign rd_rsp_o.rvalid  = rvalid_q;
	assign rd_rsp_o.rdata   = rdata_q;
	assign rd_rsp_o.rresp   = rresp_q;

	// Read data; acknowledge bit always reads zero flag mirrors latch
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
			unique case ({rd_req_i.araddr[7:2], 2'b00})
				OFF_STATUS_CONTROL: begin
					rdata_q[BIT_MODE] <= mode_q;
					rdata_q[BIT_MASK] <= mask_q;
					rdata_q[BIT_FLAG] <= latch_q;
				end
				OFF_BREAK_CTRL: rdata_q[BIT_BRK_CLR_EN] <= brk_clr_en_q;
				OFF_EVT_STATUS: rdata_q[1:0] <= evt_q;
				OFF_EVT_MASK:   rdata_q[1:0] <= evt_mask_q;
				OFF_VECTOR:     rdata_q[15:0] <= VEC_ADDR_HI;
				default:        rresp_q <= RESP_SLVERR;
			endcase
		end else if (rvalid_q && rd_req_i.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	a_edge_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		fall_edge |=> latch_q)
		else $error("falling edge did not set latch");

	a_edge_mode_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!mode_q && ack_any && !fall_edge) |=> !latch_q)
		else $error("edge mode ack did not clear latch");

	a_level_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(mode_q && latch_q && pin_low) |=> latch_q)
		else $error("level mode latch cleared while pin low");

	a_mask_blocks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mask_q |=> !cpu_irq_req_o)
		else $error("masked request reached CPU");

	a_global_mask_blocks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cpu_int_mask_i |=> !cpu_irq_req_o)
		else $error("global mask did not block request");

	a_break_protect: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(break_state_i && !brk_clr_en_q && latch_q && !vector_fetch_i) |=> latch_q)
		else $error("latch cleared in protected break");

	a_ack_reads_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rvalid_q |-> !rdata_q[BIT_ACK] || ($past(rd_req_i.araddr[7:2]) != 6'h00))
		else $error("acknowledge bit read as one");

	a_request_path: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(latch_q && !mask_q && !cpu_int_mask_i && !ack_any) |=> cpu_irq_req_o)
		else $error("unmasked latch not presented");

	a_sync_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(pin_q) |-> $past(!pin_sync_q[1], 1) && $past(!pin_sync_q[2], 1))
		else $error("pin level changed without agreement");

	a_level_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(mode_q && latch_q && ack_pend_q && !pin_low && !fall_edge) |=> !latch_q)
		else $error("level mode latch not cleared after pin high");

	a_flag_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_take && ({rd_req_i.araddr[7:2], 2'b00} == OFF_STATUS_CONTROL))
		|=> (rdata_q[BIT_FLAG] == $past(latch_q)))
		else $error("flag bit does not show latch");
endmodule
`default_nettype wire

// [logic/ext_irq_pkg.sv]
// Package: register map, field positions and carrier types of the external interrupt latch
package ext_irq_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFF_BREAK_CTRL     = 8'h04;
	localparam logic [7:0] OFF_EVT_STATUS     = 8'h08;
	localparam logic [7:0] OFF_EVT_MASK       = 8'h0C;
	localparam logic [7:0] OFF_VECTOR         = 8'h10;
	// Field positions of irq_status_control
	localparam int BIT_MODE = 0;
	localparam int BIT_MASK = 1;
	localparam int BIT_ACK  = 2;
	localparam int BIT_FLAG = 3;
	// Field position of break_flag_control_reg
	localparam int BIT_BRK_CLR_EN = 7;
	// Event status bits
	localparam int EVT_LATCH = 0;
	localparam int EVT_ACK   = 1;
	// Reset values
	localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] RST_BREAK_CTRL     = 8'h00;
	localparam logic [1:0] RST_EVT_MASK       = 2'h0;
	// Vector location of this interrupt
	localparam logic [15:0] VEC_ADDR_HI = 16'hFFFA;
	localparam logic [15:0] VEC_ADDR_LO = 16'hFFFB;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Write and read channel carriers
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
	} axi_wr_req_t;
	typedef struct packed {
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axi_rd_req_t;
	typedef struct packed {
		logic       awready;
		logic       wready;
		logic       bvalid;
		logic [1:0] bresp;
	} axi_wr_rsp_t;
	typedef struct packed {
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rd_rsp_t;
endpackage

// [test/ext_pin_source.sv]
// Behavioural external source that drives the active-low interrupt pin
`timescale 1ns/1ns
`default_nettype none
module ext_pin_source (
	input  wire logic clk_i,
	output var  logic pin_n_o
);
	// ------------------------------
	// Pin driver
	// ------------------------------
	// Idle high: the line has a pull-up whenever nobody pulls it low
	initial pin_n_o = 1'b1;
	// Low pulse of n cycles; keep n at 2 or more so the last two sync stages agree, or it is lost
	task automatic pulse(input int n);
		@(posedge clk_i) pin_n_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		pin_n_o <= 1'b1;
	endtask
	// Pull low and keep it there until released
	task automatic hold_low();
		@(posedge clk_i) pin_n_o <= 1'b0;
	endtask
	// Let the pull-up take the line back high
	task automatic release_pin();
		@(posedge clk_i) pin_n_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// [test/external_irq_latch_tb.sv]
// Self-checking bench of the external interrupt latch
`timescale 1ns/1ns
`default_nettype none
module external_irq_latch_tb;
	import ext_irq_pkg::*;
	// ------------------------------
	// Signals and instances
	// ------------------------------
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        pin_n;
	logic        vf = 1'b0;
	logic        gmask = 1'b0;
	logic        brk = 1'b0;
	logic        cpu_irq;
	logic        ev_irq;
	logic [15:0] vec;
	axi_wr_req_t wreq = '0;
	axi_wr_rsp_t wrsp;
	axi_rd_req_t rreq = '0;
	axi_rd_rsp_t rrsp;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          seed = 17;
	logic [1:0]  bq[$];
	logic [33:0] rq[$];
	// Clock at 125 MHz
	always #4 clk_i = ~clk_i;
	ext_pin_source i_src (.clk_i(clk_i), .pin_n_o(pin_n));
	external_irq_latch i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_int_pin_n_i(pin_n),
		.vector_fetch_i(vf), .cpu_int_mask_i(gmask), .break_state_i(brk), .wr_req_i(wreq),
		.wr_rsp_o(wrsp), .rd_req_i(rreq), .rd_rsp_o(rrsp), .cpu_irq_req_o(cpu_irq),
		.vector_addr_o(vec), .event_irq_o(ev_irq));
	// ------------------------------
	// Tasks
	// ------------------------------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Write: aw and w offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
		input logic [1:0] e = RESP_OKAY);
		bq.push_back(e);
		wreq <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: s, bready: 1'b1};
		do begin
			@(posedge clk_i);
			if (wreq.awvalid && wrsp.awready) wreq.awvalid <= 1'b0;
			if (wreq.wvalid && wrsp.wready) wreq.wvalid <= 1'b0;
		end while (!wrsp.bvalid);
		wreq.bready <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e = RESP_OKAY);
		rq.push_back({e, d});
		rreq <= '{arvalid: 1'b1, araddr: a, rready: 1'b1};
		do begin
			@(posedge clk_i);
			if (rreq.arvalid && rrsp.arready) rreq.arvalid <= 1'b0;
		end while (!rrsp.rvalid);
		rreq.rready <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic tend(input string t);
		$display("test %s done", t);
	endtask
	// ------------------------------
	// Response monitor and timeout
	// ------------------------------
	// Every response is matched against the oldest note of its channel
	always @(posedge clk_i) begin
		if (wrsp.bvalid && wreq.bready) chk({32'h0, wrsp.bresp}, {32'h0, bq.pop_front()});
		if (rrsp.rvalid && rreq.rready) chk({rrsp.rresp, rrsp.rdata}, rq.pop_front());
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		w(16);
		rst_n_i <= 1'b1;
		rd(OFF_STATUS_CONTROL, 32'h0);
		rd(OFF_VECTOR, 32'hFFFA);
		chk(vec, 16'hFFFA);
		rd(8'h14, 32'h0, RESP_SLVERR);
		wr(8'h14, 32'h1, 4'hF, RESP_SLVERR);
		tend("reset");
		wr(OFF_EVT_MASK, 32'h3);
		i_src.pulse(4 + ($unsigned($random(seed)) % 8));
		w(8);
		chk({ev_irq, cpu_irq}, 2'b11);
		rd(OFF_STATUS_CONTROL, 32'h8);
		rd(OFF_EVT_STATUS, 32'h1);
		w(2);
		chk(ev_irq, 1'b0);
		wr(OFF_EVT_MASK, 32'h0);
		tend("event");
		i_src.hold_low();
		w(8);
		vf <= 1'b1;
		w(1);
		vf <= 1'b0;
		w(3);
		chk(cpu_irq, 1'b0);
		rd(OFF_STATUS_CONTROL, 32'h0);
		rd(OFF_EVT_STATUS, 32'h3);
		i_src.release_pin();
		w(8);
		tend("fetch");
		i_src.pulse(5);
		w(8);
		wr(OFF_STATUS_CONTROL, ($random(seed) & 32'hFFFFFF00) | 32'h4, 4'hE);
		w(3);
		chk(cpu_irq, 1'b1);
		wr(OFF_STATUS_CONTROL, ($random(seed) & 32'hFFFFFF00) | 32'h4);
		w(3);
		chk(cpu_irq, 1'b0);
		i_src.pulse(4);
		w(8);
		chk(cpu_irq, 1'b1);
		tend("ack");
		wr(OFF_STATUS_CONTROL, 32'h2);
		w(3);
		chk(cpu_irq, 1'b0);
		rd(OFF_STATUS_CONTROL, 32'hA);
		wr(OFF_STATUS_CONTROL, 32'h0);
		w(3);
		chk(cpu_irq, 1'b1);
		gmask <= 1'b1;
		w(3);
		chk(cpu_irq, 1'b0);
		gmask <= 1'b0;
		tend("mask");
		wr(OFF_STATUS_CONTROL, 32'h5);
		w(3);
		chk(cpu_irq, 1'b0);
		i_src.hold_low();
		w(8);
		wr(OFF_STATUS_CONTROL, 32'h5);
		w(4);
		chk(cpu_irq, 1'b1);
		i_src.release_pin();
		w(8);
		chk(cpu_irq, 1'b0);
		rd(OFF_STATUS_CONTROL, 32'h1);
		tend("level");
		wr(OFF_STATUS_CONTROL, 32'h0);
		i_src.pulse(6);
		w(8);
		brk <= 1'b1;
		wr(OFF_STATUS_CONTROL, 32'h4);
		w(3);
		chk(cpu_irq, 1'b1);
		wr(OFF_BREAK_CTRL, 32'h80);
		rd(OFF_BREAK_CTRL, 32'h80);
		wr(OFF_STATUS_CONTROL, 32'h4);
		w(3);
		brk <= 1'b0;
		w(3);
		chk(cpu_irq, 1'b0);
		tend("break");
		i_src.pulse(5);
		w(8);
		chk(cpu_irq, 1'b1);
		rst_n_i <= 1'b0;
		w(2);
		rst_n_i <= 1'b1;
		w(2);
		chk(cpu_irq, 1'b0);
		rd(OFF_STATUS_CONTROL, 32'h0);
		tend("reset again");
		report_and_stop();
	end
endmodule
`default_nettype wire
